// ### verilog/stage_seq_map.vh
`ifndef STAGE_SEQ_MAP_VH
`define STAGE_SEQ_MAP_VH

// ----------------------------------------
// Run modes
// ----------------------------------------
`define MODE_OFF 2'h0
`define MODE_ONCE_STOP 2'h1
`define MODE_ONCE_HOLD 2'h2
`define MODE_CYCLE 2'h3

// ----------------------------------------
// Restart selections
// ----------------------------------------
`define RESTART_FIRST 2'h0
`define RESTART_STAGE 2'h1
`define RESTART_FREQ 2'h2

// ----------------------------------------
// Stage reference sources
// ----------------------------------------
`define SRC_MS_FREQ 2'h0
`define SRC_MAIN 2'h1
`define SRC_MS_CL 2'h2
`define SRC_CL_CHAN 2'h3

// ----------------------------------------
// Stage counts and timing
// ----------------------------------------
`define NUM_STAGES 15
`define FIRST_STAGE 4'h1
`define LAST_STAGE 4'hF
`define CLK_HZ 125000000
`define SECS_PER_MIN 60
// Last tenth-second tick within one tenth of a minute
`define SUB_LAST 6'h3B
`define TENTHS_PER_SEC 10

`endif

// ### verilog/tick_gen.v
`timescale 1ns/10ps
// Produces a one-cycle tick every DIV clock cycles while enabled
module tick_gen #(
	parameter DIV = 12500000,
	parameter W = 24
) (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Control
	input wire en,
	output reg tick
);

	reg [W-1:0] cnt_reg; // Cycle counter

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	// Count while enabled, hold position when paused
	always @(posedge clk)
	begin
		if (srst)
		begin
			cnt_reg <= {W{1'b0}};
			tick <= 1'b0;
		end
		else if (en)
		begin
			if (cnt_reg == DIV - 1)
			begin
				cnt_reg <= {W{1'b0}};
				tick <= 1'b1;
			end
			else
			begin
				cnt_reg <= cnt_reg + 1'b1;
				tick <= 1'b0;
			end
		end
		else
			tick <= 1'b0;
	end

endmodule // tick_gen

// ### verilog/ref_mux.v
`timescale 1ns/10ps
`include "stage_seq_map.vh"
// Selects the stage target from the stage setting digit
module ref_mux #(
	parameter FW = 16
) (
	input wire [1:0] src,
	input wire [FW-1:0] ms_freq,
	input wire [FW-1:0] main_ref,
	input wire [FW-1:0] ms_cl,
	input wire [FW-1:0] cl_chan,
	output reg [FW-1:0] target,
	output reg closed_loop
);

	// ----------------------------------------
	// Source decode
	// ----------------------------------------
	// Digits 0/1 are frequency targets, 2/3 closed-loop targets
	always @*
	begin
		case (src)
			`SRC_MS_FREQ: target = ms_freq;
			`SRC_MAIN: target = main_ref;
			`SRC_MS_CL: target = ms_cl;
			`SRC_CL_CHAN: target = cl_chan;
			default: target = ms_freq;
		endcase
		closed_loop = src[1];
	end

endmodule // ref_mux

// ### verilog/stage_seq.v
`timescale 1ns/10ps
`include "stage_seq_map.vh"
// Simple stage sequencer: steps through fifteen timed stages
module stage_seq #(
	parameter FW = 16,
	parameter TW = 16,
	parameter TICK_DIV = 12500000
) (
	// Clock and reset
	input wire CLK,
	input wire SRST,
	// Configuration digits
	input wire [1:0] RUN_MODE,
	input wire [1:0] RESTART_SEL,
	input wire RETAIN_SEL,
	input wire TIME_UNIT,
	// Per-stage settings, stage i at slice i-1
	input wire [2*`NUM_STAGES-1:0] STAGE_SRC,
	input wire [TW*`NUM_STAGES-1:0] STAGE_TIME,
	input wire [FW*`NUM_STAGES-1:0] MS_FREQ,
	input wire [FW*`NUM_STAGES-1:0] MS_CL,
	// Reference inputs
	input wire [FW-1:0] MAIN_REF,
	input wire [FW-1:0] CL_CHAN_REF,
	input wire [FW-1:0] RUN_FREQ,
	// Commands and terminals
	input wire RUN_CMD,
	input wire STOP_CMD,
	input wire FAULT,
	input wire POWER_LOSS,
	input wire [3:0] CL_SEL,
	// Status and outputs
	output reg ACTIVE,
	output reg RUNNING,
	output reg [3:0] STAGE,
	output reg [FW-1:0] TARGET,
	output reg TARGET_CL,
	output reg RESTORE_FREQ_VALID,
	output reg [FW-1:0] RESTORE_FREQ,
	output reg [FW-1:0] CL_SEL_REF,
	output reg CL_SEL_VALID,
	output reg PASS_DONE
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_HOLD = 2'h2;
	localparam ST_PAUSE = 2'h3;
	localparam TICK_W = 24; // Divider width, holds the full 0.1 s count

	// Pin synchronisers: first stage feeds only the second
	reg [4:0] sync1_reg; // Run, stop, fault, power loss, unit
	reg [4:0] sync2_reg;
	reg run_d_reg; // Previous run level for edge detect
	wire run_s = sync2_reg[0];
	wire stop_s = sync2_reg[1];
	wire fault_s = sync2_reg[2];
	wire pwr_s = sync2_reg[3];
	wire unit_s = sync2_reg[4];
	wire run_rise = run_s & ~run_d_reg;
	reg [3:0] cl_sync1_reg; // Selection terminals, first stage
	reg [3:0] cl_sync2_reg; // Selection terminals, second stage
	wire [3:0] cl_sel_s = cl_sync2_reg; // Terminal code in the clock domain

	reg [1:0] state_reg; // Sequencer state
	reg [3:0] stage_reg; // Current stage 1..15
	reg [TW-1:0] elapsed_reg; // Elapsed stage time in tenths
	reg [5:0] sub_reg; // Tenth-second ticks toward one tenth of a minute
	reg [FW-1:0] saved_freq_reg; // Frequency at interruption
	reg saved_valid_reg; // Saved frequency meaningful
	reg resume_freq_reg; // Restore frequency on this restart

	wire tenth_tick;
	wire [FW-1:0] sel_ms_freq;
	wire [FW-1:0] sel_ms_cl;
	wire [1:0] sel_src;
	wire [TW-1:0] sel_time;
	wire [FW-1:0] mux_target;
	wire mux_cl;

	// Stage-indexed slice pick, used for the MS_FREQ and MS_CL tables
	function [FW-1:0] pick_f;
		input [FW*`NUM_STAGES-1:0] tab;
		input [3:0] idx;
		begin
			pick_f = tab[(idx - 4'h1)*FW +: FW];
		end
	endfunction

	assign sel_ms_freq = pick_f(MS_FREQ, stage_reg);
	assign sel_ms_cl = pick_f(MS_CL, stage_reg);
	assign sel_src = STAGE_SRC[(stage_reg - 4'h1)*2 +: 2];
	assign sel_time = STAGE_TIME[(stage_reg - 4'h1)*TW +: TW];

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	// Tenth-of-second base tick, paused outside a running stage
	tick_gen #(
		.DIV(TICK_DIV),
		.W(TICK_W)
	) u_tick (
		.clk(CLK),
		.srst(SRST),
		.en(state_reg == ST_RUN),
		.tick(tenth_tick)
	);

	// Stage reference source select
	ref_mux #(
		.FW(FW)
	) u_mux (
		.src(sel_src),
		.ms_freq(sel_ms_freq),
		.main_ref(MAIN_REF),
		.ms_cl(sel_ms_cl),
		.cl_chan(CL_CHAN_REF),
		.target(mux_target),
		.closed_loop(mux_cl)
	);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			run_d_reg <= 1'b0;
			cl_sync1_reg <= 4'h0;
			cl_sync2_reg <= 4'h0;
		end
		else
		begin
			sync1_reg <= {TIME_UNIT, POWER_LOSS, FAULT, STOP_CMD, RUN_CMD};
			sync2_reg <= sync1_reg;
			cl_sync1_reg <= CL_SEL;
			cl_sync2_reg <= cl_sync1_reg;
			run_d_reg <= run_s;
		end
	end

	// Unit tick: tenths in seconds mode, tenth-of-minute boundary in minutes mode
	reg unit_tick;
	wire sec_tick = tenth_tick;
	always @*
	begin
		if (unit_s)
			unit_tick = sec_tick && (sub_reg == `SUB_LAST);
		else
			unit_tick = sec_tick;
	end

	wire stage_expire = (elapsed_reg >= sel_time);
	wire last_stage = (stage_reg == `LAST_STAGE);
	wire halt = stop_s | fault_s | pwr_s;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			state_reg <= ST_IDLE;
			stage_reg <= `FIRST_STAGE;
			elapsed_reg <= {TW{1'b0}};
			sub_reg <= 6'h00;
			saved_freq_reg <= {FW{1'b0}};
			saved_valid_reg <= 1'b0;
			resume_freq_reg <= 1'b0;
			PASS_DONE <= 1'b0;
		end
		else
		begin
			PASS_DONE <= 1'b0;
			if (RUN_MODE == `MODE_OFF)
			begin
				state_reg <= ST_IDLE;
				stage_reg <= `FIRST_STAGE;
				elapsed_reg <= {TW{1'b0}};
				sub_reg <= 6'h00;
			end
			else
			begin
				case (state_reg)
					ST_IDLE:
					begin
						if (run_rise && !halt)
						begin
							state_reg <= ST_RUN;
							stage_reg <= `FIRST_STAGE;
							elapsed_reg <= {TW{1'b0}};
							sub_reg <= 6'h00;
						end
					end
					ST_RUN:
					begin
						if (halt)
						begin
							state_reg <= ST_PAUSE;
							// Power loss without retention or restart 0 forgets
							if ((pwr_s && !RETAIN_SEL) || RESTART_SEL == `RESTART_FIRST)
							begin
								stage_reg <= `FIRST_STAGE;
								elapsed_reg <= {TW{1'b0}};
								sub_reg <= 6'h00;
								saved_valid_reg <= 1'b0;
							end
							else
							begin
								// Keep stage and elapsed time
								saved_freq_reg <= RUN_FREQ;
								saved_valid_reg <= (RESTART_SEL == `RESTART_FREQ);
							end
						end
						else if (stage_expire)
						begin
							elapsed_reg <= {TW{1'b0}};
							sub_reg <= 6'h00;
							if (last_stage)
							begin
								PASS_DONE <= 1'b1;
								case (RUN_MODE)
									`MODE_ONCE_STOP: state_reg <= ST_IDLE;
									`MODE_ONCE_HOLD: state_reg <= ST_HOLD;
									default: stage_reg <= `FIRST_STAGE;
								endcase
								if (RUN_MODE == `MODE_ONCE_STOP)
									stage_reg <= `FIRST_STAGE;
							end
							else
								stage_reg <= stage_reg + 4'h1;
						end
						else if (unit_tick)
						begin
							elapsed_reg <= elapsed_reg + 1'b1;
							sub_reg <= 6'h00;
						end
						else if (sec_tick && unit_s)
							sub_reg <= sub_reg + 6'h01;
						resume_freq_reg <= 1'b0;
					end
					ST_HOLD:
					begin
						// Hold last stage reference until a stop, fault or power loss
						if (halt)
						begin
							state_reg <= ST_IDLE;
							stage_reg <= `FIRST_STAGE;
						end
					end
					ST_PAUSE:
					begin
						// Power loss still present without retention discards state
						if (pwr_s && !RETAIN_SEL)
						begin
							stage_reg <= `FIRST_STAGE;
							elapsed_reg <= {TW{1'b0}};
							saved_valid_reg <= 1'b0;
						end
						else if (run_rise && !halt)
						begin
							state_reg <= ST_RUN;
							resume_freq_reg <= saved_valid_reg;
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	// Closed-loop reference picked by terminals, zero code means none
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			ACTIVE <= 1'b0;
			RUNNING <= 1'b0;
			STAGE <= `FIRST_STAGE;
			TARGET <= {FW{1'b0}};
			TARGET_CL <= 1'b0;
			RESTORE_FREQ_VALID <= 1'b0;
			RESTORE_FREQ <= {FW{1'b0}};
			CL_SEL_REF <= {FW{1'b0}};
			CL_SEL_VALID <= 1'b0;
		end
		else
		begin
			ACTIVE <= (RUN_MODE != `MODE_OFF) && (state_reg != ST_IDLE);
			RUNNING <= (state_reg == ST_RUN) || (state_reg == ST_HOLD);
			STAGE <= stage_reg;
			TARGET <= mux_target;
			TARGET_CL <= mux_cl;
			RESTORE_FREQ_VALID <= resume_freq_reg && (state_reg == ST_RUN);
			RESTORE_FREQ <= saved_freq_reg;
			CL_SEL_VALID <= (cl_sel_s != 4'h0);
			CL_SEL_REF <= (cl_sel_s != 4'h0) ? pick_f(MS_CL, cl_sel_s) : {FW{1'b0}};
		end
	end

endmodule // stage_seq

// ### test/stage_seq_checker.sv
`timescale 1ns/10ps
// Watches stage order and mode actions at the sequencer ports
module stage_seq_checker (
	// Clock and reset
	input wire CLK,
	input wire SRST,
	// Inputs
	input wire [1:0] RUN_MODE,
	input wire STOP_CMD,
	input wire [3:0] CL_SEL,
	// Outputs
	input wire ACTIVE,
	input wire RUNNING,
	input wire [3:0] STAGE,
	input wire CL_SEL_VALID,
	input wire PASS_DONE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	property p_off; RUN_MODE == 2'h0 [*2] |-> !ACTIVE; endproperty
	a_off: assert property (p_off) else $error("active in mode zero");
	property p_num; ACTIVE |-> STAGE != 4'h0; endproperty
	a_num: assert property (p_num) else $error("stage number zero");
	property p_step;
		$past(ACTIVE) && ACTIVE && STAGE != $past(STAGE)
			|-> STAGE == $past(STAGE) + 4'h1 || STAGE == 4'h1;
	endproperty
	a_step: assert property (p_step) else $error("stage skipped");
	property p_pass; PASS_DONE |-> $past(STAGE) == 4'hF; endproperty
	a_pass: assert property (p_pass) else $error("pass end not at last stage");
	property p_once; PASS_DONE && RUN_MODE == 2'h1 |-> ##[1:2] !RUNNING; endproperty
	a_once: assert property (p_once) else $error("no stop after pass");
	property p_hold;
		PASS_DONE && RUN_MODE == 2'h2 && !STOP_CMD |=> RUNNING && STAGE == 4'hF;
	endproperty
	a_hold: assert property (p_hold) else $error("last stage not held");
	property p_cyc; PASS_DONE && RUN_MODE == 2'h3 |-> ##[0:2] STAGE == 4'h1; endproperty
	a_cyc: assert property (p_cyc) else $error("no new pass");
	property p_stop; $rose(STOP_CMD) |-> ##[1:4] !RUNNING; endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_sel; $stable(CL_SEL) [*4] |-> CL_SEL_VALID == (CL_SEL != 4'h0); endproperty
	a_sel: assert property (p_sel) else $error("terminal select flag wrong");
	// Main scenarios reached
	c_once: cover property (PASS_DONE && RUN_MODE == 2'h1);
	c_hold: cover property (PASS_DONE && RUN_MODE == 2'h2);
	c_cyc: cover property (PASS_DONE && RUN_MODE == 2'h3);
endmodule // stage_seq_checker
bind stage_seq stage_seq_checker i_stage_seq_checker (.CLK, .SRST, .RUN_MODE, .STOP_CMD,
	.CL_SEL, .ACTIVE, .RUNNING, .STAGE, .CL_SEL_VALID, .PASS_DONE);

// ### test/stage_cmd_partner.sv
`timescale 1ns/10ps
// Operator side: run and stop levels plus the running frequency
module stage_cmd_partner (
	// Clock and bench requests
	input wire clk,
	input wire go,
	input wire halt,
	input wire [15:0] freq,
	// Levels toward the sequencer
	output reg RUN_CMD,
	output reg STOP_CMD,
	output reg [15:0] RUN_FREQ
);
	// Commands change just after the clock edge, like a real panel latch
	initial {RUN_CMD, STOP_CMD, RUN_FREQ} = 18'h0;
	always @(posedge clk)
	begin
		RUN_CMD <= go;
		STOP_CMD <= halt;
		RUN_FREQ <= freq;
	end
endmodule // stage_cmd_partner

// ### test/stage_seq_bench.sv
`timescale 1ns/10ps
module stage_seq_bench;
	reg CLK = 0, SRST = 1, TIME_UNIT = 0, RETAIN_SEL = 0, FAULT = 0, POWER_LOSS = 0;
	reg go = 0, halt = 0;
	reg [1:0] RUN_MODE = 0, RESTART_SEL = 0, src;
	reg [3:0] CL_SEL = 0;
	reg [29:0] STAGE_SRC = 0;
	reg [239:0] STAGE_TIME = 0, MS_FREQ = 0, MS_CL = 0;
	reg [15:0] MAIN_REF = 0, CL_CHAN_REF = 0, freq = 0;
	wire RUN_CMD, STOP_CMD, ACTIVE, RUNNING, TARGET_CL, RESTORE_FREQ_VALID;
	wire CL_SEL_VALID, PASS_DONE;
	wire [3:0] STAGE;
	wire [15:0] TARGET, RESTORE_FREQ, RUN_FREQ, CL_SEL_REF;
	integer failures = 0, n_compared = 0, cyc = 0, i, k, n, tm[1:15];
	integer n_restore = 0, m, st;
	// Counts one-cycle frequency restore pulses
	always @(negedge CLK)
		if (RESTORE_FREQ_VALID === 1'b1)
			n_restore <= n_restore + 1;
	// Short tick so a stage count lasts ten clocks
	stage_seq #(.TICK_DIV(10)) i_stage_seq (.CLK, .SRST, .RUN_MODE, .RESTART_SEL,
		.RETAIN_SEL, .TIME_UNIT, .STAGE_SRC, .STAGE_TIME, .MS_FREQ, .MS_CL, .MAIN_REF,
		.CL_CHAN_REF, .RUN_FREQ, .RUN_CMD, .STOP_CMD, .FAULT, .POWER_LOSS, .CL_SEL,
		.ACTIVE, .RUNNING, .STAGE, .TARGET, .TARGET_CL, .RESTORE_FREQ_VALID,
		.RESTORE_FREQ, .CL_SEL_REF, .CL_SEL_VALID, .PASS_DONE);
	stage_cmd_partner i_stage_cmd_partner (.clk(CLK), .go, .halt, .freq, .RUN_CMD,
		.STOP_CMD, .RUN_FREQ);
	initial forever #4 CLK = ~CLK;
	// Cuts a hang short
	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			failures = failures + 1;
			give_verdict;
		end
	end
	task give_verdict;
		begin
			if (failures == 0 && n_compared > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task cmp(input [15:0] got, input [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp)
			begin
				failures = failures + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Stage length within one tick plus command latency
	task cmp_span(input integer got, input integer exp);
		begin
			n_compared = n_compared + 1;
			if (got < exp - 12 || got > exp + 12)
			begin
				failures = failures + 1;
				$display("mismatch at %0t: stage took %0d expected %0d", $time, got, exp);
			end
		end
	endtask
	task tick(input integer c);
		repeat (c) @(negedge CLK);
	endtask
	task start;
		begin
			go = 0;
			tick(2);
			go = 1;
			tick(8);
		end
	endtask
	task stop_all;
		begin
			halt = 1;
			tick(8);
			halt = 0;
		end
	endtask
	// Waits for a stage change, a pass end or a halt
	task wait_move(output integer c);
		reg [3:0] s;
		begin
			s = STAGE;
			c = 0;
			while (STAGE === s && RUNNING === 1'b1 && PASS_DONE !== 1'b1 && c < 5000)
			begin
				tick(1);
				c = c + 1;
			end
		end
	endtask
	// Reference model of stage number and target
	task chk(input integer s);
		begin
			tick(1);
			src = STAGE_SRC[2*s-2+:2];
			cmp(STAGE, s);
			cmp(TARGET_CL, src[1]);
			case (src)
				2'h0: cmp(TARGET, MS_FREQ[16*s-16+:16]);
				2'h1: cmp(TARGET, MAIN_REF);
				2'h2: cmp(TARGET, MS_CL[16*s-16+:16]);
				default: cmp(TARGET, CL_CHAN_REF);
			endcase
		end
	endtask
	initial
	begin
		k = $urandom(19);
		MAIN_REF = 16'($urandom);
		CL_CHAN_REF = 16'($urandom);
		for (i = 1; i < 16; i = i + 1)
		begin
			tm[i] = 2 + $urandom % 2;
			STAGE_TIME[16*i-16+:16] = 16'(tm[i]);
			MS_FREQ[16*i-16+:16] = 16'($urandom);
			MS_CL[16*i-16+:16] = 16'($urandom);
			STAGE_SRC[2*i-2+:2] = 2'(i);
		end
		tick(16);
		SRST = 0;
		tick(1);
		cmp(STAGE, 1);
		start;
		cmp(ACTIVE, 0);
		// One full pass in each active mode
		for (k = 1; k < 4; k = k + 1)
		begin
			RUN_MODE = 2'(k);
			start;
			cmp(ACTIVE, 1);
			for (i = 1; i < 16; i = i + 1)
			begin
				chk(i);
				wait_move(n);
				cmp_span(n, tm[i] * 10);
			end
			cmp(PASS_DONE, 1);
			tick(3);
			cmp(RUNNING, k > 1);
			cmp(STAGE, (k == 2) ? 15 : 1);
			stop_all;
		end
		// Stop, fault and power loss, then resume
		for (k = 0; k < 5; k = k + 1)
		begin
			RESTART_SEL = (k == 0) ? 2'h0 : (k == 2) ? 2'h2 : 2'h1;
			RETAIN_SEL = (k == 4);
			freq = 16'($urandom);
			start;
			wait_move(n);
			wait_move(n);
			st = STAGE;
			halt = (k < 2);
			FAULT = (k == 2);
			POWER_LOSS = (k > 2);
			tick(8);
			cmp(RUNNING, 0);
			{halt, FAULT, POWER_LOSS} = 3'h0;
			m = n_restore;
			start;
			chk((k == 1 || k == 2 || k == 4) ? st : 1);
			cmp(n_restore - m, k == 2);
			cmp(RESTORE_FREQ_VALID, 0);
			if (k == 2)
				cmp(RESTORE_FREQ, freq);
			stop_all;
		end
		// Mode zero clears kept state, then stage time in minutes
		RUN_MODE = 2'h0;
		tick(3);
		cmp(ACTIVE, 0);
		TIME_UNIT = 1;
		RUN_MODE = 2'h1;
		start;
		wait_move(n);
		cmp_span(n, tm[1] * 600);
		stop_all;
		// Terminal selection of stored closed-loop references
		for (k = 1; k < 16; k = k + 1)
		begin
			CL_SEL = 4'(k);
			tick(5);
			cmp(CL_SEL_REF, MS_CL[16*k-16+:16]);
			cmp(CL_SEL_VALID, 1);
		end
		CL_SEL = 4'h0;
		tick(5);
		cmp(CL_SEL_VALID, 0);
		give_verdict;
	end
endmodule // stage_seq_bench
